// ### acsp_device.sv
// converter end of the serial command port: command decode,
// register file, word shifter and ready line
// assumes sclk, cs_n and sdi are asynchronous to hclk and much slower
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module acsp_device (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    acsp_if.dev                 link,
    input  wire acsp_pkg::acsp_word_type result_word,
    input  wire logic           result_load,
    output acsp_pkg::acsp_word_type config_word,
    output logic                config_update,
    output acsp_pkg::acsp_word_type trim_word
);
    import acsp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_CMD    = 5'b00001,
        ST_DECODE = 5'b00010,
        ST_READ   = 5'b00100,
        ST_WRITE  = 5'b01000,
        ST_DONE   = 5'b10000
    } acsp_dev_state_type;

    acsp_dev_state_type state_q;
    acsp_word_type      regs_q [NUM_REGS];
    acsp_word_type      shift_q;
    acsp_cnt_type       cnt_q;
    acsp_cnt_type       wait_q;
    acsp_tgt_type       tgt_q;
    logic               sclk_prev_q;
    logic               sdo_q;
    logic               sdo_oe_q;
    logic               ready_n_q;
    logic               cfg_upd_q;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0] pins_raw;
    logic [2:0] pins_s;
    assign pins_raw = {link.sclk, link.cs_n, link.sdi};

    acsp_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (pins_raw),
        .q     (pins_s)
    );

    wire sclk_s   = pins_s[2];
    wire cs_off   = pins_s[1];
    wire sdi_s    = pins_s[0];
    // edges only count while selected
    wire sclk_up  = !cs_off && sclk_s && !sclk_prev_q;
    wire sclk_dn  = !cs_off && !sclk_s && sclk_prev_q;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    acsp_cmd_type  cmd_w;
    acsp_tgt_type  cmd_tgt;
    logic          cmd_rd;
    logic          cmd_ok;
    acsp_word_type word_in;
    logic          wr_fire;

    assign cmd_w   = {shift_q[CMD_LAST-1:0], sdi_s};
    assign cmd_tgt = cmd_w[TGT_HI:TGT_LO];
    assign cmd_rd  = cmd_w[DIR_POS];
    // a bad frame is dropped and the port keeps listening
    assign cmd_ok  = cmd_w[CMD_MARK] && (cmd_w[PAD_HI:0] == 3'h0)
                     && (cmd_tgt != TGT_UNUSED)
                     && !(cmd_tgt == TGT_RESULT && !cmd_rd);
    assign word_in = {shift_q[WORD_MSB-1:0], sdi_s};
    assign wr_fire = (state_q == ST_WRITE) && sclk_up && (cnt_q == DATA_LAST);

    // ------------------------------------------------------------
    // port sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= ST_CMD;
            shift_q     <= '0;
            cnt_q       <= '0;
            wait_q      <= '0;
            tgt_q       <= TGT_RESULT;
            sclk_prev_q <= 1'b0;
            sdo_q       <= 1'b0;
            sdo_oe_q    <= 1'b0;
            ready_n_q   <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            if (cs_off) begin
                // deselect aborts any phase, short result reads included
                state_q   <= ST_CMD;
                cnt_q     <= '0;
                sdo_oe_q  <= 1'b0;
                ready_n_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_CMD: begin
                        if (sclk_up) begin
                            shift_q <= word_in;
                            cnt_q   <= cnt_q + 5'h01;
                            if (cnt_q == CMD_LAST) begin
                                cnt_q <= '0;
                                tgt_q <= cmd_tgt;
                                if (cmd_ok && cmd_rd) begin
                                    state_q <= ST_DECODE;
                                    wait_q  <= DECODE_CYC;
                                end else if (cmd_ok) begin
                                    state_q <= ST_WRITE;
                                end
                            end
                        end
                    end
                    ST_DECODE: begin
                        wait_q <= wait_q - 5'h01;
                        if (wait_q == 5'h01) begin
                            shift_q   <= regs_q[tgt_q];
                            sdo_q     <= regs_q[tgt_q][WORD_MSB];
                            sdo_oe_q  <= 1'b1;
                            ready_n_q <= 1'b0;
                            state_q   <= ST_READ;
                        end
                    end
                    ST_READ: begin
                        if (sclk_dn) begin
                            shift_q <= {shift_q[WORD_MSB-1:0], 1'b0};
                            sdo_q   <= shift_q[WORD_MSB-1];
                        end
                        if (sclk_up) begin
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == DATA_LAST) begin
                                state_q   <= ST_DONE;
                                ready_n_q <= 1'b1;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (sclk_up) begin
                            shift_q <= word_in;
                            cnt_q   <= cnt_q + 5'h01;
                            if (wr_fire) begin
                                state_q <= ST_CMD;
                                cnt_q   <= '0;
                            end
                        end
                    end
                    ST_DONE: begin
                        // hold the last bit until the host's closing fall
                        if (sclk_dn) begin
                            sdo_oe_q <= 1'b0;
                            state_q  <= ST_CMD;
                            cnt_q    <= '0;
                        end
                    end
                    default: begin
                        state_q <= ST_CMD;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // result refreshes only while the host has let go of the port
    wire result_take = result_load && cs_off;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regs_q[TGT_RESULT] <= '0;
        end else if (result_take) begin
            regs_q[TGT_RESULT] <= result_word;
        end
    end

    // trim field follows the trim register, writes to it are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regs_q[TGT_CONFIG] <= CFG_RESET;
        end else if (wr_fire && tgt_q == TGT_CONFIG) begin
            regs_q[TGT_CONFIG] <= {regs_q[TGT_CONFIG][TRIM_HI:TRIM_LO],
                                   word_in[TRIM_LO-1:0]};
        end else if (wr_fire && tgt_q == TGT_TRIM) begin
            regs_q[TGT_CONFIG][TRIM_HI:TRIM_LO] <= word_in[TRIM_SRC:0];
        end
    end

    // calibration and trim words: plain stores
    for (genvar i = TGT_GAIN; i < NUM_REGS; i++) begin : g_reg
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                regs_q[i] <= '0;
            end else if (wr_fire && tgt_q == acsp_tgt_type'(i)) begin
                regs_q[i] <= word_in;
            end
        end
    end

    // new configuration is handed to the converter core at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_upd_q <= 1'b0;
        end else begin
            cfg_upd_q <= wr_fire && (tgt_q == TGT_CONFIG);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.sdo            = sdo_q;
    assign link.sdo_oe         = sdo_oe_q;
    assign link.result_ready_n = ready_n_q;
    assign config_word         = regs_q[TGT_CONFIG];
    assign config_update       = cfg_upd_q;
    assign trim_word           = regs_q[TGT_TRIM];

endmodule : acsp_device

`default_nettype wire

// ### acsp_pkg.sv
// constants, types and register map of the serial command port
// assumes a 20 MHz hclk shared by both ends of the link
package acsp_pkg;

    // ------------------------------------------------------------
    // word sizes and command byte layout
    // ------------------------------------------------------------
    typedef logic [23:0] acsp_word_type;
    typedef logic [7:0]  acsp_cmd_type;
    typedef logic [2:0]  acsp_tgt_type;
    typedef logic [4:0]  acsp_cnt_type;

    localparam acsp_cnt_type CMD_LAST  = 5'h07;
    localparam acsp_cnt_type DATA_LAST = 5'h17;
    localparam acsp_cnt_type DATA_BITS = 5'h18;
    localparam int           CMD_MARK  = 7;
    localparam int           TGT_HI    = 6;
    localparam int           TGT_LO    = 4;
    localparam int           DIR_POS   = 3;
    localparam int           PAD_HI    = 2;
    localparam int           WORD_MSB  = 23;

    // ------------------------------------------------------------
    // device registers selected by the target field
    // ------------------------------------------------------------
    localparam acsp_tgt_type TGT_RESULT = 3'h0;
    localparam acsp_tgt_type TGT_CONFIG = 3'h1;
    localparam acsp_tgt_type TGT_GAIN   = 3'h2;
    localparam acsp_tgt_type TGT_TRIM   = 3'h3;
    localparam acsp_tgt_type TGT_RATIO  = 3'h4;
    localparam acsp_tgt_type TGT_INPUT  = 3'h5;
    localparam acsp_tgt_type TGT_REF    = 3'h6;
    localparam acsp_tgt_type TGT_UNUSED = 3'h7;
    localparam int           NUM_REGS   = 7;

    // trim sign and magnitude sit at the top of the configuration word
    localparam int            TRIM_HI   = 23;
    localparam int            TRIM_LO   = 20;
    localparam int            TRIM_SRC  = 3;
    localparam acsp_word_type CFG_RESET = 24'h000000;

    // ------------------------------------------------------------
    // host register map, byte addresses on AHB-Lite
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_CMD    = 8'h00;
    localparam logic [7:0] HOST_TX     = 8'h04;
    localparam logic [7:0] HOST_RX     = 8'h08;
    localparam logic [7:0] HOST_STATUS = 8'h0C;
    localparam int         LEN_HI      = 20;
    localparam int         LEN_LO      = 16;
    localparam int         ST_BUSY     = 0;
    localparam int         ST_DONE     = 1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCLK_HALF_NS  = 250;
    localparam int DECODE_NS     = 1000;
    localparam acsp_cnt_type SCLK_HALF_CYC =
        5'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam acsp_cnt_type DECODE_CYC =
        5'((DECODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : acsp_pkg

// ### acsp_if.sv
// link wires between the host controller and the converter port
// assumes the bench resolves the data-out wire from sdo_oe
`timescale 1ns/10ps
`default_nettype none

interface acsp_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic result_ready_n;

    modport dev  (input sclk, cs_n, sdi, output sdo, sdo_oe, result_ready_n);
    modport host (output sclk, cs_n, sdi, input sdo, sdo_oe, result_ready_n);
endinterface : acsp_if

`default_nettype wire

// ### acsp_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes nothing reads the first stage but the second
`timescale 1ns/10ps
`default_nettype none

module acsp_sync #(
    parameter int             WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= INIT[i];
                q[i]      <= INIT[i];
            end else begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end
endmodule : acsp_sync

`default_nettype wire

// ### acsp_host.sv
// host controller end: AHB-Lite register slave that runs one
// command frame on the link per start
// assumes sdo and result_ready_n are asynchronous to hclk
`timescale 1ns/10ps
`default_nettype none

module acsp_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    acsp_if.host             link
);
    import acsp_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_CMD  = 5'b00010,
        H_WAIT = 5'b00100,
        H_DATA = 5'b01000,
        H_END  = 5'b10000
    } acsp_host_state_type;

    acsp_host_state_type state_q;
    logic [31:0]   sh_q;
    acsp_word_type tx_q;
    acsp_word_type rx_q;
    acsp_cnt_type  cnt_q;
    acsp_cnt_type  div_q;
    acsp_cnt_type  len_q;
    logic          rd_q;
    logic          done_q;
    logic          sclk_q;
    logic          cs_n_q;
    logic          sdi_q;
    logic          wr_pend_q;
    logic [7:0]    addr_q;
    logic [31:0]   hrdata_q;

    // ------------------------------------------------------------
    // bus slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    wire addr_ph  = hsel && htrans[1] && hready;
    wire wr_en    = wr_pend_q;
    wire idle     = (state_q == H_IDLE);
    wire start    = wr_en && (addr_q == HOST_CMD) && idle;
    wire tx_wr    = wr_en && (addr_q == HOST_TX) && idle;
    wire done_clr = wr_en && (addr_q == HOST_STATUS) && hwdata[ST_DONE];
    wire tick     = (div_q == SCLK_HALF_CYC - 5'h01);
    wire done_set = (state_q == H_END) && tick;
    wire [31:0] status_w = {30'h0, done_q, !idle};
    logic [31:0] rd_mux;

    always_comb begin
        case (haddr[7:0])
            HOST_CMD:    rd_mux = {24'h0, sh_q[31:24]};
            HOST_TX:     rd_mux = {8'h0, tx_q};
            HOST_RX:     rd_mux = {8'h0, rx_q};
            HOST_STATUS: rd_mux = status_w;
            default:     rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata_q  <= 32'h0;
            tx_q      <= '0;
            done_q    <= 1'b0;
        end else begin
            wr_pend_q <= addr_ph && hwrite;
            if (addr_ph) begin
                addr_q   <= haddr[7:0];
                hrdata_q <= rd_mux;
            end
            if (tx_wr) begin
                tx_q <= hwdata[WORD_MSB:0];
            end
            // a finishing frame outranks a clear in the same cycle
            done_q <= done_set || (done_q && !done_clr);
        end
    end

    // ------------------------------------------------------------
    // link synchronisers and clock divider
    // ------------------------------------------------------------
    logic [1:0] in_s;
    acsp_sync #(.WIDTH(2), .INIT(2'h1)) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({link.sdo, link.result_ready_n}),
        .q     (in_s)
    );
    wire sdo_s   = in_s[1];
    wire ready_s = !in_s[0];
    wire fall    = tick && sclk_q;
    wire [4:0] last_bit = (rd_q && len_q != 5'h00 && len_q < DATA_BITS)
                          ? len_q - 5'h01 : DATA_LAST;

    // ------------------------------------------------------------
    // frame sequencer: sdi changes on falls, sdo taken before each fall
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= H_IDLE;
            sh_q    <= 32'h0;
            rx_q    <= '0;
            cnt_q   <= '0;
            div_q   <= '0;
            len_q   <= '0;
            rd_q    <= 1'b0;
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            sdi_q   <= 1'b0;
        end else begin
            div_q <= (tick || idle || state_q == H_WAIT) ? 5'h00 : div_q + 5'h01;
            if (tick && state_q != H_END) begin
                sclk_q <= !sclk_q;
            end
            case (state_q)
                H_IDLE: begin
                    if (start) begin
                        sh_q    <= {hwdata[7:0], tx_q};
                        sdi_q   <= hwdata[CMD_MARK];
                        rd_q    <= hwdata[DIR_POS];
                        // only result reads may be cut short
                        len_q   <= (hwdata[TGT_HI:TGT_LO] == TGT_RESULT)
                                   ? hwdata[LEN_HI:LEN_LO] : 5'h00;
                        cs_n_q  <= 1'b0;
                        cnt_q   <= '0;
                        state_q <= H_CMD;
                    end
                end
                H_CMD: begin
                    if (fall) begin
                        sh_q  <= {sh_q[30:0], 1'b0};
                        sdi_q <= sh_q[30];
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == CMD_LAST) begin
                            cnt_q   <= '0;
                            state_q <= rd_q ? H_WAIT : H_DATA;
                        end
                    end
                end
                H_WAIT: begin
                    if (ready_s) begin
                        state_q <= H_DATA;
                    end
                end
                H_DATA: begin
                    if (fall) begin
                        sh_q  <= {sh_q[30:0], 1'b0};
                        sdi_q <= rd_q ? 1'b0 : sh_q[30];
                        cnt_q <= cnt_q + 5'h01;
                        if (rd_q) begin
                            rx_q <= {rx_q[WORD_MSB-1:0], sdo_s};
                        end
                        if (cnt_q == last_bit) begin
                            state_q <= H_END;
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        cs_n_q  <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign link.sclk  = sclk_q;
    assign link.cs_n  = cs_n_q;
    assign link.sdi   = sdi_q;

endmodule : acsp_host

`default_nettype wire

// ### acsp_sva.sv
// link checker for the serial command port
// assumes hclk and hresetn are the shared domain of both ends
`timescale 1ns/10ps
`default_nettype none
module acsp_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic result_ready_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence sclk_hi_s; sclk [*4] ##[1:2] !sclk; endsequence
    // five cycles covers the sync delay on cs_n
    sequence quiet_s; cs_n [*5]; endsequence
    idle_sclk_a: assert property (cs_n |-> !sclk)
        else $error("sclk moves while deselected");
    oe_release_a: assert property (quiet_s |-> !sdo_oe)
        else $error("sdo driven while deselected");
    ready_release_a: assert property (quiet_s |-> result_ready_n)
        else $error("ready low while deselected");
    ready_oe_a: assert property ($fell(result_ready_n) |-> ##[0:3] sdo_oe)
        else $error("ready without driven sdo");
    read_pause_a: assert property ($fell(result_ready_n) |-> !$past(cs_n, 20))
        else $error("ready too soon after select");
    sclk_half_a: assert property ($rose(sclk) |-> sclk_hi_s)
        else $error("sclk high phase wrong");
    sdo_hold_a: assert property (sclk && $past(sclk) && sdo_oe |-> $stable(sdo))
        else $error("sdo moved while sclk high");
    cs_end_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk, 4))
        else $error("frame ended during a clock");
endmodule : acsp_sva
`default_nettype wire

// ### acsp_bench.sv
// bench joining host and device ends through one link
// assumes zero-wait AHB-Lite slave and W1C done flag
`timescale 1ns/10ps
`default_nettype none
module acsp_bench;
    import acsp_pkg::*;
    logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, result_load, config_update;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [31:0]   haddr, hwdata, hrdata;
    acsp_word_type result_word, config_word, trim_word;
    int            err_total = 0, compares = 0, upd_n = 0;
    acsp_if acsp_if_inst ();
    acsp_device acsp_device_inst (.hclk(hclk), .hresetn(hresetn), .link(acsp_if_inst.dev),
        .result_word(result_word), .result_load(result_load), .config_word(config_word),
        .config_update(config_update), .trim_word(trim_word));
    acsp_host acsp_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(acsp_if_inst.host));
    acsp_sva acsp_sva_inst (.hclk(hclk), .hresetn(hresetn), .sclk(acsp_if_inst.sclk),
        .cs_n(acsp_if_inst.cs_n), .sdi(acsp_if_inst.sdi), .sdo(acsp_if_inst.sdo),
        .sdo_oe(acsp_if_inst.sdo_oe), .result_ready_n(acsp_if_inst.result_ready_n));
    always #25 hclk = ~hclk;
    always @(posedge hclk) if (config_update === 1'b1) upd_n <= upd_n + 1;
    // ------------------------------------------------------------
    // bus and frame tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : chk
    task hung(input string m);
        err_total++;
        $display("[FAIL] %0t timeout %s", $time, m);
        tally_and_finish();
    endtask : hung
    task wait_rdy;
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) hung("hready");
    endtask : wait_rdy
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    task frame(input logic [31:0] tx, input logic [31:0] cmd, output logic [31:0] rx);
        logic [31:0] d;
        int          n;
        ahb(1'b1, HOST_TX, tx, d);
        ahb(1'b1, HOST_CMD, cmd, d);
        n = 0;
        do begin ahb(1'b0, HOST_STATUS, 32'h0, d); n++; end while (d[ST_DONE] !== 1'b1 && n < 1000);
        if (n >= 1000) hung("frame");
        ahb(1'b1, HOST_STATUS, 32'h2, d);
        ahb(1'b0, HOST_RX, 32'h0, rx);
    endtask : frame
    task load(input acsp_word_type w);
        result_word <= w;
        result_load <= 1'b1;
        @(posedge hclk);
        result_load <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : load
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_cfg;
        logic [31:0] r;
        chk(config_word, CFG_RESET, "config reset");
        // reserved bits kept zero, trim field set to show it is dropped
        frame(32'h00F4A4A1, 32'h90, r);
        chk(config_word, 24'h04A4A1, "config write");
        chk(24'(upd_n), 24'h1, "config update");
        $display("t_cfg done");
    endtask : t_cfg
    task t_trim;
        logic [31:0] r;
        frame(32'h0000000A, 32'hB0, r);
        chk(trim_word, 24'h00000A, "trim write");
        frame(32'h0, 32'h98, r);
        chk(r[23:0], 24'hA4A4A1, "config read mirror");
        $display("t_trim done");
    endtask : t_trim
    task t_gain;
        logic [31:0] r;
        logic [7:0]  tg [3] = '{8'hC0, 8'hD0, 8'hE0};
        // all three calibration words first, so aliased targets show up
        foreach (tg[i]) frame(32'h00F00000 | 32'(i), {24'h0, tg[i]}, r);
        foreach (tg[i]) begin
            frame(32'h0, {24'h0, tg[i] | 8'h08}, r);
            chk(r[23:0], 24'hF00000 | 24'(i), "calibration read");
        end
        frame(32'h00123456, 32'hA0, r);
        frame(32'h0, 32'hA8, r);
        chk(r[23:0], 24'h123456, "gain read");
        $display("t_gain done");
    endtask : t_gain
    task t_bad;
        logic [31:0] r;
        logic [7:0]  bad [4] = '{8'h11, 8'h97, 8'hF0, 8'h80};
        foreach (bad[i]) frame(32'h0, {24'h0, bad[i]}, r);
        chk(config_word, 24'hA4A4A1, "invalid commands");
        chk(24'(upd_n), 24'h1, "no update on invalid");
        $display("t_bad done");
    endtask : t_bad
    task t_result;
        logic [31:0] r;
        load(24'hABCDEF);
        frame(32'h0, 32'h00080088, r);
        // upper bits keep the previous read word, shifted up by eight
        chk(r[23:0], 24'h3456AB, "short result read");
        load(24'h13579B);
        frame(32'h0, 32'h88, r);
        chk(r[23:0], 24'h13579B, "fresh result read");
        $display("t_result done");
    endtask : t_result
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel <= 1'b1;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        result_word <= 24'h0;
        result_load <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_cfg();
        t_trim();
        t_gain();
        t_bad();
        t_result();
        tally_and_finish();
    end
endmodule : acsp_bench
`default_nettype wire
